// ---- core/bapm_dme_tx.sv ----
// Differential Manchester serialiser for one 49-bit page
`timescale 1ns/1ps
`include "bapm_regs.svh"
module bapm_dme_tx (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Page request
  input wire logic start_i,
  input wire logic [48:0] page_i,
  output logic busy_o,
  output logic done_o,
  // Line
  output logic line_o
);
  logic [48:0] sh_ff;
  logic [5:0] bits_ff;
  logic [7:0] half_ff;
  logic mid_ff;
  logic line_ff;

  assign busy_o = (bits_ff != 6'h00);
  assign line_o = line_ff;

  // Cell timing and level flips at every boundary and for ones mid-cell
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sh_ff <= '0;
      bits_ff <= 6'h00;
      half_ff <= 8'h00;
      mid_ff <= 1'b0;
      line_ff <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o) begin
        if (start_i) begin
          sh_ff <= page_i;
          bits_ff <= `BAPM_PAGE_BITS;
          half_ff <= 8'(`BAPM_HALF_CYC - 32'd1);
          mid_ff <= 1'b0;
          line_ff <= ~line_ff; // [R3]
        end
      end else if (half_ff != 8'h00) begin
        half_ff <= half_ff - 8'h01;
      end else begin
        half_ff <= 8'(`BAPM_HALF_CYC - 32'd1);
        mid_ff <= ~mid_ff;
        if (!mid_ff) begin
          if (sh_ff[0]) begin
            line_ff <= ~line_ff; // [R3]
          end
        end else begin
          sh_ff <= {1'b0, sh_ff[48:1]};
          bits_ff <= bits_ff - 6'h01;
          if (bits_ff == 6'h01) begin
            done_o <= 1'b1;
          end else begin
            line_ff <= ~line_ff; // [R3]
          end
        end
      end
    end
  end
endmodule : bapm_dme_tx

// ---- core/bapm_fifo.sv ----
// Small valid/ready FIFO for received codewords
`timescale 1ns/1ps
module bapm_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  logic [AW:0] nxt_cnt;
  logic ready_ff;

  // Handshakes and honest flags; ready is registered from the next fill count
  assign in_ready_o = ready_ff;
  assign nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      ready_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ff <= (int'(wr_ff) == DEPTH - 1) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (int'(rd_ff) == DEPTH - 1) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      ready_ff <= (int'(nxt_cnt) < DEPTH);
    end
  end
endmodule : bapm_fifo

// ---- core/bapm_page_match.sv ----
// Auto-negotiation page builder, matcher and arbitration core with Wishbone registers
`timescale 1ns/1ps
`include "bapm_regs.svh"
module bapm_page_match (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Received codewords from the page receiver
  input wire logic rx_valid_i,
  input wire logic [47:0] rx_word_i,
  output logic rx_ready_o,
  // Transmit line
  output logic tx_line_o,
  output logic tx_en_o,
  // State view
  output logic [2:0] arb_state_o
);
  bapm_pkg::bapm_arb_e st_ff;
  logic [3:0] ctrl_ff;
  logic [47:0] base_ff;
  logic [47:0] npg_ff;
  logic [31:0] brk_ff;
  logic [31:0] brk_cnt_ff;
  logic [6:0] prbs_ff;
  logic [4:0] nonce_ff;
  logic [4:0] nrng_ff;
  logic [47:0] last_ff;
  logic [47:0] agreed_ff;
  logic [47:0] rxlog_ff;
  logic [1:0] abil_cnt_ff;
  logic [1:0] ack_cnt_ff;
  logic [3:0] sent_ack_ff;
  logic [3:0] ack_goal_ff;
  logic tx_ack_ff;
  logic tog_ff;
  logic lp_np_ff;
  logic cons_ff;
  logic np_phase_ff;
  logic tx_line_ff;
  logic tx_en_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [47:0] fw;
  logic fvalid;
  logic pop;
  logic same;
  logic abil_hit;
  logic ack_hit;
  logic tx_start;
  logic tx_busy;
  logic tx_done;
  logic dme_line;
  logic [47:0] cur_pg;
  logic [48:0] tx_page;
  logic wr;
  logic [3:0] idx;
  logic [31:0] wcur;
  logic [31:0] wnew;
  logic dme_rst;

  // Codeword with acknowledge removed for comparisons
  function automatic logic [47:0] strip_ack(input logic [47:0] w);
    strip_ack = w & ~(48'h1 << `BAPM_BIT_ACK);
  endfunction : strip_ack

  // Codeword without acknowledge and echoed nonce, for the consistency test
  function automatic logic [47:0] strip_echo(input logic [47:0] w);
    strip_echo = strip_ack(w) & ~(48'h1f << `BAPM_EN_LSB);
  endfunction : strip_echo

  // Byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction : merge

  // Received codeword buffer
  bapm_fifo #(.WIDTH(48), .DEPTH(4)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i(rx_word_i),
    .out_valid_o(fvalid),
    .out_ready_i(pop),
    .out_data_o(fw)
  );

  // Serialiser, held idle while transmission is off so a cut page stops at once
  assign dme_rst = srst_i || !tx_en_ff;
  bapm_dme_tx u_dme (
    .ref_clk_i(ref_clk_i),
    .srst_i(dme_rst),
    .start_i(tx_start),
    .page_i(tx_page),
    .busy_o(tx_busy),
    .done_o(tx_done),
    .line_o(dme_line)
  );

  // One codeword is judged per cycle while the arbiter is live
  assign pop = fvalid && (st_ff != bapm_pkg::ST_DISABLE);
  assign same = (strip_ack(fw) == strip_ack(last_ff));
  assign abil_hit = pop && same && (abil_cnt_ff == `BAPM_MATCH_CNT - 2'h1); // [R7]
  assign ack_hit = pop && fw[`BAPM_BIT_ACK] && (fw == last_ff)
    && (ack_cnt_ff == `BAPM_MATCH_CNT - 2'h1); // [R11]

  // Page contents: base or next page, acknowledge and echoed nonce
  always_comb begin
    cur_pg = np_phase_ff ? npg_ff : base_ff; // [R4]
    if (np_phase_ff) begin
      if (!ctrl_ff[`BAPM_CTRL_UNF]) begin
        cur_pg[10:0] = `BAPM_NULL_MSG; // [R5]
      end
      cur_pg[12] = ~ctrl_ff[`BAPM_CTRL_UNF]; // [R5]
      cur_pg[`BAPM_BIT_TOG] = tog_ff; // [R6]
    end else begin
      cur_pg[`BAPM_TN_LSB +: `BAPM_NONCE_W] = nonce_ff;
      cur_pg[`BAPM_EN_LSB +: `BAPM_NONCE_W] = tx_ack_ff ? last_ff[`BAPM_TN_LSB +: 5] : 5'h00; // [R13]
    end
    cur_pg[`BAPM_BIT_ACK] = tx_ack_ff; // [R8]
    cur_pg[`BAPM_BIT_NP] = np_phase_ff ? npg_ff[`BAPM_BIT_NP] : ctrl_ff[`BAPM_CTRL_NP];
    tx_page = {prbs_ff[6], cur_pg}; // [R1]
  end
  assign tx_start = !tx_busy && tx_en_ff && (st_ff != bapm_pkg::ST_DISABLE);

  // Bit-49 generator steps once per page
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      prbs_ff <= 7'h7f;
    end else if (tx_done) begin
      prbs_ff <= {prbs_ff[5:0], ctrl_ff[`BAPM_CTRL_POLY] ? (prbs_ff[6] ^ prbs_ff[5])
        : (prbs_ff[6] ^ prbs_ff[2])}; // [R1] [R2]
    end
  end

  // Free-running nonce source
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      nrng_ff <= 5'h00;
    end else begin
      nrng_ff <= nrng_ff + 5'h01;
    end
  end

  // Match counters restart on any change of codeword; the ability count ignores a change of acknowledge alone
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      last_ff <= '0;
      abil_cnt_ff <= 2'h0;
      ack_cnt_ff <= 2'h0;
    end else if (pop) begin
      last_ff <= fw;
      if (!same) begin
        abil_cnt_ff <= 2'h1; // [R17]
      end else if (abil_cnt_ff != `BAPM_MATCH_CNT) begin
        abil_cnt_ff <= abil_cnt_ff + 2'h1;
      end
      if (!fw[`BAPM_BIT_ACK] || fw != last_ff) begin
        ack_cnt_ff <= {1'b0, fw[`BAPM_BIT_ACK]}; // [R17]
      end else if (ack_cnt_ff != `BAPM_MATCH_CNT) begin
        ack_cnt_ff <= ack_cnt_ff + 2'h1;
      end
    end
  end

  // Arbitration
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_ff <= bapm_pkg::ST_DISABLE;
      nonce_ff <= 5'h00;
      tx_ack_ff <= 1'b0;
      tx_en_ff <= 1'b0;
      brk_cnt_ff <= '0;
      agreed_ff <= '0;
      cons_ff <= 1'b1;
      sent_ack_ff <= 4'h0;
      ack_goal_ff <= `BAPM_ACK_MIN;
      tog_ff <= 1'b0;
      lp_np_ff <= 1'b0;
      np_phase_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        bapm_pkg::ST_DISABLE: begin
          tx_en_ff <= 1'b0;
          tx_ack_ff <= 1'b0;
          np_phase_ff <= 1'b0;
          if (brk_cnt_ff != '0) begin
            brk_cnt_ff <= brk_cnt_ff - 32'd1; // [R16]
          end else if (ctrl_ff[`BAPM_CTRL_EN]) begin
            st_ff <= bapm_pkg::ST_ABILITY;
            nonce_ff <= nrng_ff ^ prbs_ff[4:0]; // [R12]
            tx_en_ff <= 1'b1;
            cons_ff <= 1'b1;
          end
        end
        bapm_pkg::ST_ABILITY: begin
          if (abil_hit && fw[`BAPM_TN_LSB +: 5] == nonce_ff) begin
            st_ff <= bapm_pkg::ST_DISABLE; // [R10]
            brk_cnt_ff <= brk_ff; // [R16]
            tx_en_ff <= 1'b0;
          end else if (abil_hit) begin
            st_ff <= bapm_pkg::ST_ACK_DET; // [R8]
            tx_ack_ff <= 1'b1; // [R8] [R9]
            agreed_ff <= strip_ack(fw);
            lp_np_ff <= fw[`BAPM_BIT_NP];
          end
        end
        bapm_pkg::ST_ACK_DET: begin
          if (ack_hit && strip_echo(fw) != strip_echo(agreed_ff) && !np_phase_ff) begin
            cons_ff <= 1'b0; // [R14]
            st_ff <= bapm_pkg::ST_DISABLE;
            brk_cnt_ff <= brk_ff;
          end else if (ack_hit && !np_phase_ff
              && fw[`BAPM_EN_LSB +: 5] != nonce_ff) begin
            st_ff <= bapm_pkg::ST_DISABLE;
            brk_cnt_ff <= brk_ff;
          end else if (ack_hit) begin
            st_ff <= bapm_pkg::ST_CMPL_ACK; // [R11]
            sent_ack_ff <= 4'h0;
            ack_goal_ff <= `BAPM_ACK_MIN + {2'h0, nrng_ff[1:0] == 2'h3 ? 2'h0 : nrng_ff[1:0]};
          end
        end
        bapm_pkg::ST_CMPL_ACK: begin
          if (tx_done) begin
            sent_ack_ff <= sent_ack_ff + 4'h1;
            if (sent_ack_ff + 4'h1 >= ack_goal_ff) begin // [R15]
              tx_ack_ff <= 1'b0;
              if ((ctrl_ff[`BAPM_CTRL_NP] && !np_phase_ff) || (np_phase_ff
                  && npg_ff[`BAPM_BIT_NP]) || lp_np_ff) begin
                st_ff <= bapm_pkg::ST_NP_WAIT; // [R6]
                if (np_phase_ff) begin
                  tog_ff <= ~tog_ff; // [R6]
                end else begin
                  tog_ff <= base_ff[`BAPM_TN_LSB];
                end
                np_phase_ff <= 1'b1;
              end else begin
                st_ff <= bapm_pkg::ST_GOOD;
              end
            end
          end
        end
        bapm_pkg::ST_NP_WAIT: begin
          if (abil_hit) begin
            st_ff <= bapm_pkg::ST_ACK_DET;
            tx_ack_ff <= 1'b1; // [R6]
            agreed_ff <= strip_ack(fw);
            lp_np_ff <= fw[`BAPM_BIT_NP];
          end
        end
        bapm_pkg::ST_GOOD: begin
          tx_en_ff <= 1'b0;
          if (!ctrl_ff[`BAPM_CTRL_EN]) begin
            st_ff <= bapm_pkg::ST_DISABLE;
          end
        end
        default: st_ff <= bapm_pkg::ST_DISABLE;
      endcase
    end
  end

  // Captured last codeword for software
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rxlog_ff <= '0;
    end else if (pop) begin
      rxlog_ff <= fw;
    end
  end

  // Wishbone slave: one wait cycle, ack for one cycle, write lands on the ack edge
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign idx = wb_adr_i[5:2];

  // Addressed word for reads and as the base of a byte-lane write
  always_comb begin
    unique case (idx)
      `BAPM_ADR_CTRL: wcur = {28'h0, ctrl_ff};
      `BAPM_ADR_BASE_LO: wcur = base_ff[31:0];
      `BAPM_ADR_BASE_HI: wcur = {16'h0, base_ff[47:32]};
      `BAPM_ADR_NP_LO: wcur = npg_ff[31:0];
      `BAPM_ADR_NP_HI: wcur = {16'h0, npg_ff[47:32]};
      `BAPM_ADR_BRK: wcur = brk_ff;
      `BAPM_ADR_STAT: wcur = {16'h0, 3'h0, nonce_ff, cons_ff, tx_ack_ff, np_phase_ff,
        tog_ff, abil_cnt_ff == `BAPM_MATCH_CNT, ack_cnt_ff == `BAPM_MATCH_CNT, 1'b0,
        st_ff == bapm_pkg::ST_GOOD};
      `BAPM_ADR_RXLO: wcur = rxlog_ff[31:0];
      `BAPM_ADR_RXHI: wcur = {16'h0, rxlog_ff[47:32]};
      default: wcur = 32'h0000_0000;
    endcase
    wnew = merge(wcur, wb_dat_i, wb_sel_i);
  end

  // Register file and read data
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= '0;
      ctrl_ff <= 4'h0;
      base_ff <= 48'h0000_0000_0001;
      npg_ff <= '0;
      brk_ff <= `BAPM_BRK_RST;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
      if (wr) begin
        unique case (idx)
          `BAPM_ADR_CTRL: ctrl_ff <= wnew[3:0];
          `BAPM_ADR_BASE_LO: base_ff[31:0] <= wnew;
          `BAPM_ADR_BASE_HI: base_ff[47:32] <= wnew[15:0];
          `BAPM_ADR_NP_LO: npg_ff[31:0] <= wnew;
          `BAPM_ADR_NP_HI: npg_ff[47:32] <= wnew[15:0];
          `BAPM_ADR_BRK: brk_ff <= wnew;
          default: ;
        endcase
      end
      rdat_ff <= wcur;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // Registered line outputs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tx_line_ff <= 1'b0;
    end else begin
      tx_line_ff <= dme_line && tx_busy;
    end
  end
  assign tx_line_o = tx_line_ff;
  assign tx_en_o = tx_en_ff;
  assign arb_state_o = st_ff;
endmodule : bapm_page_match

// ---- core/bapm_pkg.sv ----
// Types shared by the page logic
package bapm_pkg;
  typedef enum logic [2:0] {
    ST_DISABLE = 3'b000,
    ST_ABILITY = 3'b001,
    ST_ACK_DET = 3'b010,
    ST_CMPL_ACK = 3'b011,
    ST_NP_WAIT = 3'b100,
    ST_GOOD = 3'b101
  } bapm_arb_e;
  typedef logic [47:0] bapm_word_t;
endpackage : bapm_pkg

// ---- core/bapm_regs.svh ----
// Register offsets, field positions, reset values and timing counts for the page logic
// Summary of operation
// R1: Bit 49 comes from a 7-stage PRBS, polynomial x7+x3+1 or x7+x6+1 selectable.
// R2: The bit-49 generator advances every page so repeated pages vary.
// R3: Page bits are differential Manchester coded; ones add a mid-cell transition.
// R4: Next-page exchange is always supported.
// R5: Next pages sent are null message or unformatted pages.
// R6: Next pages carry correct toggle and acknowledge; exchange ends when both more_pages_flag clear.
// R7: Page agreement after three consecutive identical codewords, acknowledge ignored.
// R8: Agreement with foreign nonce leaves ability detect and sets transmitted acknowledge.
// R9: Alternating differing codewords never give agreement; acknowledge stays clear.
// R10: Own nonce received means silence for break-link time, then base page again.
// R11: Acknowledge seen after three consecutive codewords with acknowledge set.
// R12: A new 5-bit nonce is drawn on every entry to ability detect.
// R13: Echoed nonce field is zero while transmitted acknowledge is zero.
// R14: Acknowledged codeword differing from agreed one clears consistency, goes to disable; the code checks this for base pages only, not next pages.
// R15: Acknowledgement finishes after six to eight pages sent with acknowledge set.
// R16: Break-link silence is a configurable cycle count.
// R17: Match counters restart whenever a received codeword differs from the previous one; the ability count ignores acknowledge.
`ifndef BAPM_REGS_SVH
`define BAPM_REGS_SVH
`define BAPM_ADR_CTRL 4'h0
`define BAPM_ADR_BASE_LO 4'h1
`define BAPM_ADR_BASE_HI 4'h2
`define BAPM_ADR_NP_LO 4'h3
`define BAPM_ADR_NP_HI 4'h4
`define BAPM_ADR_BRK 4'h5
`define BAPM_ADR_STAT 4'h6
`define BAPM_ADR_RXLO 4'h7
`define BAPM_ADR_RXHI 4'h8
`define BAPM_CTRL_EN 0
`define BAPM_CTRL_POLY 1
`define BAPM_CTRL_NP 2
`define BAPM_CTRL_UNF 3
`define BAPM_BIT_ACK 14
`define BAPM_BIT_NP 15
`define BAPM_BIT_TOG 11
`define BAPM_EN_LSB 5
`define BAPM_TN_LSB 16
`define BAPM_NONCE_W 5
`define BAPM_MATCH_CNT 2'h3
`define BAPM_ACK_MIN 4'h6
`define BAPM_BRK_RST 32'h0000_0fff
`define BAPM_CELL_NS 32'd64
`define BAPM_CLK_NS 32'd10
`define BAPM_HALF_CYC ((`BAPM_CELL_NS / `BAPM_CLK_NS) / 32'd2)
`define BAPM_PAGE_BITS 6'h31
`define BAPM_NULL_MSG 11'h001
`endif

// ---- testbench/bapm_lp_model.sv ----
// Link partner model that hands received codewords to the page logic
`timescale 1ns/1ps
module bapm_lp_model (
  // Clock
  input wire logic ref_clk_i,
  // Codeword handshake
  input wire logic lp_ready_i,
  output logic lp_valid_o,
  output logic [47:0] lp_word_o
);
  // Idle at time zero
  initial begin
    lp_valid_o = 1'b0;
    lp_word_o = 48'h0;
  end
  // Offer one codeword after a pause, hold it until the edge that takes it
  task automatic send_word(input logic [47:0] w, input int pause);
    int n;
    n = 0;
    repeat (pause) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    lp_valid_o <= 1'b1;
    lp_word_o <= w;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (lp_ready_i !== 1'b1 && n < 5000);
    lp_valid_o <= 1'b0;
    lp_word_o <= ~w; // Released bus shows no stale codeword
  endtask : send_word
endmodule : bapm_lp_model

// ---- testbench/bapm_page_match_sva.sv ----
// Port-level assertion checker for the page logic, bound into its top module
`timescale 1ns/1ps
module bapm_page_match_sva (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Wishbone handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Receive, transmit and state
  input wire logic rx_ready_o,
  input wire logic tx_line_o,
  input wire logic tx_en_o,
  input wire logic [2:0] arb_state_o
);
  logic line_ff;
  logic [3:0] still_ff;
  logic [11:0] cack_ff;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Cycles without a line change while transmitting
  always_ff @(posedge ref_clk_i) begin
    line_ff <= tx_line_o;
    if (srst_i || !tx_en_o || tx_line_o != line_ff) begin
      still_ff <= 4'h0;
    end else if (still_ff != 4'hf) begin
      still_ff <= still_ff + 4'h1;
    end
  end
  // Cycles spent in complete acknowledge
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || arb_state_o != 3'h3) begin
      cack_ff <= 12'h0;
    end else if (cack_ff != 12'hfff) begin
      cack_ff <= cack_ff + 12'h1;
    end
  end
  a_ack_one_cycle: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus answer late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer held too long");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus answer without request");
  a_dme_boundary: assert property (still_ff < 4'h7)
    else $error("line cell without boundary transition");
  a_dme_half_cell: assert property ((tx_en_o && $changed(tx_line_o)) |=>
    (!tx_en_o || $stable(tx_line_o)) [*2])
    else $error("line transitions closer than half a cell");
  a_quiet_disable: assert property ((arb_state_o == 3'h0 && $past(arb_state_o) == 3'h0)
    |-> !tx_en_o)
    else $error("transmitting in disable state");
  a_quiet_line: assert property ((arb_state_o == 3'h0 && $past(arb_state_o) == 3'h0
    && $past(arb_state_o, 2) == 3'h0 && $past(arb_state_o, 3) == 3'h0) |-> !tx_line_o)
    else $error("line toggles during break-link silence");
  a_enter_ack_det: assert property (($changed(arb_state_o) && arb_state_o == 3'h2)
    |-> $past(arb_state_o) inside {3'h1, 3'h4})
    else $error("ack detect entered from wrong state");
  a_enter_cmpl_ack: assert property (($changed(arb_state_o) && arb_state_o == 3'h3)
    |-> $past(arb_state_o) == 3'h2)
    else $error("complete ack entered from wrong state");
  a_ack_fin_max: assert property (cack_ff <= 12'ha56)
    else $error("complete ack lasts over eight pages");
  a_ack_fin_min: assert property ((arb_state_o != 3'h3 && $past(arb_state_o) == 3'h3)
    |-> $past(cack_ff) >= 12'h5be)
    else $error("complete ack left before six pages");
  // Main scenarios
  c_ack_det: cover property (arb_state_o == 3'h2);
  c_cmpl_ack: cover property (arb_state_o == 3'h3);
  c_fifo_full: cover property (!rx_ready_o);
  c_np_wait: cover property (arb_state_o == 3'h4);
  c_to_disable: cover property ($changed(arb_state_o) && arb_state_o == 3'h0);
endmodule : bapm_page_match_sva

bind bapm_page_match bapm_page_match_sva u_sva (
  .ref_clk_i(ref_clk_i),
  .srst_i(srst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .rx_ready_o(rx_ready_o),
  .tx_line_o(tx_line_o),
  .tx_en_o(tx_en_o),
  .arb_state_o(arb_state_o)
);

// ---- testbench/tb.sv ----
// Self-checking bench for the page logic with a link partner model
`timescale 1ns/1ps
`include "bapm_regs.svh"
module tb;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic rx_valid_i;
  logic [47:0] rx_word_i;
  logic rx_ready_o;
  logic tx_line_o;
  logic tx_en_o;
  logic [2:0] arb_state_o;
  int n_mismatch = 0;
  int checks_done = 0;
  int c;
  logic [31:0] rd;
  logic [4:0] own;
  logic [47:0] w;

  // Design and far side
  bapm_page_match u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i),
    .rx_word_i(rx_word_i), .rx_ready_o(rx_ready_o), .tx_line_o(tx_line_o),
    .tx_en_o(tx_en_o), .arb_state_o(arb_state_o));
  bapm_lp_model u_lp (.ref_clk_i(ref_clk_i), .lp_ready_i(rx_ready_o),
    .lp_valid_o(rx_valid_i), .lp_word_o(rx_word_i));

  // Clock
  always #5 ref_clk_i = ~ref_clk_i;

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [3:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task automatic wait_state(input logic [2:0] s, input int limit);
    c = 0;
    while (arb_state_o !== s && c < limit) begin
      @(posedge ref_clk_i);
      c++;
    end
    check("arb_state", 48'(arb_state_o), 48'(s));
  endtask : wait_state

  function automatic logic [47:0] mk(input logic [4:0] tn, input logic ack,
                                     input logic [4:0] en);
    mk = 48'h1 | (48'(tn) << `BAPM_TN_LSB) | (48'(ack) << `BAPM_BIT_ACK) |
      (48'(en) << `BAPM_EN_LSB);
  endfunction : mk

  task automatic t_regs();
    wb_xfer(1'b0, 4'h1, 32'h0);
    check("base_lo", 48'(rd), 48'h1);
    wb_xfer(1'b0, 4'h5, 32'h0);
    check("brk_reset", 48'(rd), 48'hfff);
    wb_xfer(1'b1, 4'h5, 32'h14);
    wb_xfer(1'b0, 4'h5, 32'h0);
    check("brk", 48'(rd), 48'h14);
    wb_xfer(1'b1, 4'h9, 32'hffff_ffff);
    wb_xfer(1'b0, 4'h9, 32'h0);
    check("unmapped", 48'(rd), 48'h0);
  endtask : t_regs

  task automatic t_fifo();
    for (int i = 0; i < 4; i++) begin
      u_lp.send_word(mk(5'h3, 1'b0, 5'h0) ^ (48'(i % 2) << 30), i);
    end
    repeat (2) @(posedge ref_clk_i);
    check("fifo_full", 48'(rx_ready_o), 48'h0);
    wb_xfer(1'b1, 4'h0, 32'h3);
    wait_state(3'h1, 400);
    repeat (8) @(posedge ref_clk_i);
    check("fifo_drained", 48'(rx_ready_o), 48'h1);
    wb_xfer(1'b0, 4'h6, 32'h0);
    check("no_agree", 48'({rd[6], rd[3]}), 48'h0);
  endtask : t_fifo

  task automatic t_nonce();
    wb_xfer(1'b0, 4'h6, 32'h0);
    repeat (3) u_lp.send_word(mk(rd[12:8], 1'b0, 5'h0), 2);
    wait_state(3'h0, 50);
    wait_state(3'h1, 80);
    check("brk_len", 48'(c > 14 && c < 30), 48'h1);
  endtask : t_nonce

  task automatic t_agree();
    wb_xfer(1'b0, 4'h6, 32'h0);
    own = rd[12:8];
    w = mk(~own, 1'b0, 5'h0) | 48'h20_0000;
    repeat (2) u_lp.send_word(w, 0);
    repeat (4) @(posedge ref_clk_i);
    check("two_pages", 48'(arb_state_o), 48'h1);
    u_lp.send_word(w, 0);
    wait_state(3'h2, 20);
    wb_xfer(1'b0, 4'h6, 32'h0);
    check("tx_ack", 48'(rd[6]), 48'h1);
  endtask : t_agree

  task automatic t_consist();
    t_agree();
    repeat (3) u_lp.send_word(mk(~own, 1'b1, own) | 48'h420_0000, 0);
    wait_state(3'h0, 20);
    wb_xfer(1'b0, 4'h6, 32'h0);
    check("consist", 48'(rd[7]), 48'h0);
    wait_state(3'h1, 80);
  endtask : t_consist

  task automatic t_ack();
    t_agree();
    repeat (2) u_lp.send_word(mk(~own, 1'b1, own) | 48'h20_0000, 1);
    repeat (4) @(posedge ref_clk_i);
    check("two_acks", 48'(arb_state_o), 48'h2);
    u_lp.send_word(mk(~own, 1'b1, own) | 48'h20_0000, 0);
    wait_state(3'h3, 20);
    c = 0;
    while (arb_state_o === 3'h3 && c < 3000) begin
      @(posedge ref_clk_i);
      c++;
    end
    check("ack_pages", 48'(c >= 1470 && c <= 2646), 48'h1);
  endtask : t_ack

  task automatic t_np();
    wb_xfer(1'b1, 4'h0, 32'h0);
    wb_xfer(1'b1, 4'h0, 32'h5);
    t_ack();
    wait_state(3'h4, 20);
    wb_xfer(1'b0, 4'h6, 32'h0);
    check("np_phase", 48'({rd[5], rd[4]}), 48'h2);
    w = 48'h0000_0000_2001;
    repeat (3) u_lp.send_word(w, 0);
    wait_state(3'h2, 20);
    repeat (3) u_lp.send_word(w | 48'h4000, 0);
    wait_state(3'h3, 20);
    wait_state(3'h5, 2700);
  endtask : t_np

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_fifo();
    t_nonce();
    t_consist();
    t_ack();
    t_np();
    report_and_stop();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb
